/* hw/prcg_top.sv */
// module: wishbone register block driving peripheral reset lines and fast bus clock gates
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
module prcg_top
    import prcg_pkg::*;
(
    input  wire logic                   SYS_CLK,
    input  wire logic                   RST,
    input  wire logic                   WB_CYC_I,
    input  wire logic                   WB_STB_I,
    input  wire logic                   WB_WE_I,
    input  wire logic [PRCG_ADDR_W-1:0] WB_ADR_I,
    input  wire logic [3:0]             WB_SEL_I,
    input  wire logic [31:0]            WB_DAT_I,
    output logic      [31:0]            WB_DAT_O,
    output logic                        WB_ACK_O,
    output logic                        WB_ERR_O,
    input  wire logic                   CPU_SLEEP,
    output prcg_upper_s                 UPPER_RESET,
    output prcg_lower_s                 LOWER_RESET,
    output prcg_gate_s                  CLOCK_ENABLE
);

    // ==========================================================
    // bus decode
    logic        req;
    logic        hit_upper;
    logic        hit_lower;
    logic        hit_gate;
    logic        hit_any;
    logic        wr_take;
    logic [31:0] be_mask;
    logic [31:0] rd_next;

    logic [31:0] upper_reg;
    logic [31:0] lower_reg;
    logic [31:0] gate_reg;
    logic        ack_reg;
    logic        err_reg;
    logic [31:0] dat_reg;

    // new request only while no answer is standing, giving one answer per request
    assign req       = WB_CYC_I && WB_STB_I && !ack_reg && !err_reg;
    assign hit_upper = (WB_ADR_I == PRCG_OFS_RST_UPPER);
    assign hit_lower = (WB_ADR_I == PRCG_OFS_RST_LOWER);
    assign hit_gate  = (WB_ADR_I == PRCG_OFS_CLK_GATE);
    assign hit_any   = hit_upper || hit_lower || hit_gate;
    assign wr_take   = req && WB_WE_I && hit_any;
    assign be_mask   = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] msk);
        merge = ((old & ~(be_mask)) | (WB_DAT_I & be_mask)) & msk;
    endfunction

    // ==========================================================
    // registers
    // upper reset bits stored
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            upper_reg <= PRCG_RST_RST_UPPER;
        end else if (wr_take && hit_upper) begin
            upper_reg <= merge(upper_reg, PRCG_MASK_RST_UPPER);
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            lower_reg <= PRCG_RST_RST_LOWER;
        end else if (wr_take && hit_lower) begin
            lower_reg <= merge(lower_reg, PRCG_MASK_RST_LOWER);
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            gate_reg <= PRCG_RST_CLK_GATE;
        end else if (wr_take && hit_gate) begin
            gate_reg <= merge(gate_reg, PRCG_MASK_CLK_GATE);
        end
    end

    // ==========================================================
    // bus answer
    always_comb begin
        rd_next = 32'h0000_0000;
        if (hit_upper) begin
            rd_next = upper_reg;
        end else if (hit_lower) begin
            rd_next = lower_reg;
        end else if (hit_gate) begin
            rd_next = gate_reg;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= req && hit_any;
            err_reg <= req && !hit_any;
            dat_reg <= (req && !WB_WE_I) ? rd_next : 32'h0000_0000;
        end
    end

    assign WB_ACK_O = ack_reg;
    assign WB_ERR_O = err_reg;
    assign WB_DAT_O = dat_reg;

    // ==========================================================
    // reset lines, registered so outputs come from flip-flops
    // held while bit set
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            UPPER_RESET <= '0;
            LOWER_RESET <= '0;
        end else begin
            UPPER_RESET <= '{upper_reg[PRCG_BIT_SYS_CONFIG], upper_reg[PRCG_BIT_CONVERTER],
                             upper_reg[PRCG_BIT_ADV_TIMER], upper_reg[PRCG_BIT_SERIAL_ONE],
                             upper_reg[PRCG_BIT_USART_ONE], upper_reg[PRCG_BIT_TIMER_FIFTEEN],
                             upper_reg[PRCG_BIT_TIMER_SIXTEEN], upper_reg[PRCG_BIT_TIMER_SEVENTN],
                             upper_reg[PRCG_BIT_DEBUG_UNIT]};
            LOWER_RESET <= '{lower_reg[PRCG_BIT_TIMER_TWO], lower_reg[PRCG_BIT_TIMER_THREE],
                             lower_reg[PRCG_BIT_TIMER_SIX], lower_reg[PRCG_BIT_TIMER_FOURTEEN],
                             lower_reg[PRCG_BIT_WATCHDOG], lower_reg[PRCG_BIT_SERIAL_TWO],
                             lower_reg[PRCG_BIT_USART_TWO], lower_reg[PRCG_BIT_TWO_WIRE_ONE],
                             lower_reg[PRCG_BIT_TWO_WIRE_TWO], lower_reg[PRCG_BIT_POWER_IF],
                             lower_reg[PRCG_BIT_DAC_CONV], lower_reg[PRCG_BIT_CONSUMER_CTRL]};
        end
    end

    // ==========================================================
    // clock gates; memory and flash always run while awake, their bit only matters in sleep
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            CLOCK_ENABLE <= '{PRCG_RST_CLK_GATE[PRCG_BIT_DMA], PRCG_RST_CLK_GATE[PRCG_BIT_SRAM],
                              PRCG_RST_CLK_GATE[PRCG_BIT_FLASH], PRCG_RST_CLK_GATE[PRCG_BIT_CRC],
                              PRCG_RST_CLK_GATE[PRCG_BIT_PORT_A], PRCG_RST_CLK_GATE[PRCG_BIT_PORT_B],
                              PRCG_RST_CLK_GATE[PRCG_BIT_PORT_C], PRCG_RST_CLK_GATE[PRCG_BIT_PORT_D],
                              PRCG_RST_CLK_GATE[PRCG_BIT_PORT_F], PRCG_RST_CLK_GATE[PRCG_BIT_TOUCH]};
        end else begin
            CLOCK_ENABLE.dma_clock_enable              <= gate_reg[PRCG_BIT_DMA];
            CLOCK_ENABLE.crc_clock_enable              <= gate_reg[PRCG_BIT_CRC];
            CLOCK_ENABLE.port_a_clock_enable           <= gate_reg[PRCG_BIT_PORT_A];
            CLOCK_ENABLE.port_b_clock_enable           <= gate_reg[PRCG_BIT_PORT_B];
            CLOCK_ENABLE.port_c_clock_enable           <= gate_reg[PRCG_BIT_PORT_C];
            CLOCK_ENABLE.port_d_clock_enable           <= gate_reg[PRCG_BIT_PORT_D];
            CLOCK_ENABLE.port_f_clock_enable           <= gate_reg[PRCG_BIT_PORT_F];
            CLOCK_ENABLE.touch_controller_clock_enable <= gate_reg[PRCG_BIT_TOUCH];
            CLOCK_ENABLE.sram_sleep_clock_enable       <= !CPU_SLEEP || gate_reg[PRCG_BIT_SRAM];
            CLOCK_ENABLE.flash_interface_clock_enable  <= !CPU_SLEEP || gate_reg[PRCG_BIT_FLASH];
        end
    end

    // gated peripherals read zero: they see CLOCK_ENABLE low and must zero their own read data.
    // this block exports the enables; the read mux sits in each peripheral.

endmodule // prcg_top

/* hw/prcg_pkg.sv */
// package: register map, field masks and reset values of the peripheral reset and clock gate block
// How it works
// - upper reset bits set hold their peripheral in reset; zero writes leave peripheral running
// - lower reset bits set hold their peripheral in reset; clear means no effect
// - both reset registers come out of system reset as all zeros
// - fast bus clock gate resets with only memory and flash enables set
// - each fast bus clock enable bit gates its peripheral clock, 1 runs; the memory and flash bits gate only during sleep
// - memory enable bit keeps memory clock running during sleep when set
// - flash enable bit keeps flash interface clock running during sleep when set
// - reads of a gated peripheral's registers return zero; this block only exports the enables, each peripheral zeroes its own read data
// - word, half-word and byte accesses complete with one wait state, ack registered in the cycle after the request
// - every defined bit can be set and cleared by software
// - upper reset register sits at offset 0x0c
package prcg_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0]  PRCG_OFS_RST_UPPER = 8'h0c;
    localparam logic [7:0]  PRCG_OFS_RST_LOWER = 8'h10;
    localparam logic [7:0]  PRCG_OFS_CLK_GATE  = 8'h14;
    localparam int          PRCG_ADDR_W        = 8;

    // ==========================================================
    // writable bit masks, reserved bits read zero
    localparam logic [31:0] PRCG_MASK_RST_UPPER = 32'h0047_5a01;
    localparam logic [31:0] PRCG_MASK_RST_LOWER = 32'h7062_4913;
    localparam logic [31:0] PRCG_MASK_CLK_GATE  = 32'h015e_0055;

    // ==========================================================
    // reset values
    localparam logic [31:0] PRCG_RST_RST_UPPER = 32'h0000_0000;
    localparam logic [31:0] PRCG_RST_RST_LOWER = 32'h0000_0000;
    localparam logic [31:0] PRCG_RST_CLK_GATE  = 32'h0000_0014;

    // ==========================================================
    // field positions of the fast bus clock gate
    localparam int PRCG_BIT_DMA   = 0;
    localparam int PRCG_BIT_SRAM  = 2;
    localparam int PRCG_BIT_FLASH = 4;
    localparam int PRCG_BIT_CRC   = 6;
    localparam int PRCG_BIT_PORT_A = 17;
    localparam int PRCG_BIT_PORT_B = 18;
    localparam int PRCG_BIT_PORT_C = 19;
    localparam int PRCG_BIT_PORT_D = 20;
    localparam int PRCG_BIT_PORT_F = 22;
    localparam int PRCG_BIT_TOUCH  = 24;

    // ==========================================================
    // field positions of the upper reset register
    localparam int PRCG_BIT_SYS_CONFIG    = 0;
    localparam int PRCG_BIT_CONVERTER     = 9;
    localparam int PRCG_BIT_ADV_TIMER     = 11;
    localparam int PRCG_BIT_SERIAL_ONE    = 12;
    localparam int PRCG_BIT_USART_ONE     = 14;
    localparam int PRCG_BIT_TIMER_FIFTEEN = 16;
    localparam int PRCG_BIT_TIMER_SIXTEEN = 17;
    localparam int PRCG_BIT_TIMER_SEVENTN = 18;
    localparam int PRCG_BIT_DEBUG_UNIT    = 22;

    // ==========================================================
    // field positions of the lower reset register
    localparam int PRCG_BIT_TIMER_TWO      = 0;
    localparam int PRCG_BIT_TIMER_THREE    = 1;
    localparam int PRCG_BIT_TIMER_SIX      = 4;
    localparam int PRCG_BIT_TIMER_FOURTEEN = 8;
    localparam int PRCG_BIT_WATCHDOG       = 11;
    localparam int PRCG_BIT_SERIAL_TWO     = 14;
    localparam int PRCG_BIT_USART_TWO      = 17;
    localparam int PRCG_BIT_TWO_WIRE_ONE   = 21;
    localparam int PRCG_BIT_TWO_WIRE_TWO   = 22;
    localparam int PRCG_BIT_POWER_IF       = 28;
    localparam int PRCG_BIT_DAC_CONV       = 29;
    localparam int PRCG_BIT_CONSUMER_CTRL  = 30;

    // ==========================================================
    // upper reset fields
    typedef struct packed {
        logic system_config_reset;
        logic converter_reset;
        logic advanced_timer_reset;
        logic serial_port_one_reset;
        logic usart_one_reset;
        logic timer_fifteen_reset;
        logic timer_sixteen_reset;
        logic timer_seventeen_reset;
        logic debug_unit_reset;
    } prcg_upper_s;

    // lower reset fields
    typedef struct packed {
        logic timer_two_reset;
        logic timer_three_reset;
        logic timer_six_reset;
        logic timer_fourteen_reset;
        logic window_watchdog_reset;
        logic serial_port_two_reset;
        logic usart_two_reset;
        logic two_wire_one_reset;
        logic two_wire_two_reset;
        logic power_interface_reset;
        logic dac_reset;
        logic consumer_control_reset;
    } prcg_lower_s;

    // fast bus clock gate fields
    typedef struct packed {
        logic dma_clock_enable;
        logic sram_sleep_clock_enable;
        logic flash_interface_clock_enable;
        logic crc_clock_enable;
        logic port_a_clock_enable;
        logic port_b_clock_enable;
        logic port_c_clock_enable;
        logic port_d_clock_enable;
        logic port_f_clock_enable;
        logic touch_controller_clock_enable;
    } prcg_gate_s;

endpackage : prcg_pkg

/* verif/prcg_chk.sv */
// checker: bus timing and reset line properties of the reset and clock gate block
`timescale 1ns/1ps
module prcg_chk
    import prcg_pkg::*;
(
    input wire logic                   SYS_CLK,
    input wire logic                   RST,
    input wire logic                   WB_CYC_I,
    input wire logic                   WB_STB_I,
    input wire logic                   WB_WE_I,
    input wire logic [PRCG_ADDR_W-1:0] WB_ADR_I,
    input wire logic [3:0]             WB_SEL_I,
    input wire logic [31:0]            WB_DAT_I,
    input wire logic [31:0]            WB_DAT_O,
    input wire logic                   WB_ACK_O,
    input wire logic                   WB_ERR_O,
    input wire logic                   CPU_SLEEP,
    input wire prcg_upper_s            UPPER_RESET,
    input wire prcg_lower_s            LOWER_RESET,
    input wire prcg_gate_s             CLOCK_ENABLE
);
    // ==========
    // properties
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    logic req;
    logic mapped;
    // a held request is taken once, not again in its ack cycle
    assign req    = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
    assign mapped = WB_ADR_I inside {PRCG_OFS_RST_UPPER, PRCG_OFS_RST_LOWER, PRCG_OFS_CLK_GATE};
    ack_next_a: assert property (req && mapped |=> WB_ACK_O && !WB_ERR_O)
        else $error("mapped request not acknowledged after one cycle");
    err_next_a: assert property (req && !mapped |=> WB_ERR_O && !WB_ACK_O)
        else $error("unmapped request not refused after one cycle");
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack stood longer than one cycle");
    rst_zero_a: assert property (disable iff (1'b0) RST |=> UPPER_RESET == '0 && LOWER_RESET == '0)
        else $error("reset lines not cleared by system reset");
    gate_rst_a: assert property (disable iff (1'b0) RST |=> CLOCK_ENABLE == 10'h180)
        else $error("clock enables wrong after system reset");
    upper_hold_a: assert property (!$past(RST) && $changed(UPPER_RESET) |->
        $past(WB_ACK_O && WB_WE_I && WB_ADR_I == PRCG_OFS_RST_UPPER))
        else $error("upper reset lines moved without a write");
    lower_hold_a: assert property (!$past(RST) && $changed(LOWER_RESET) |->
        $past(WB_ACK_O && WB_WE_I && WB_ADR_I == PRCG_OFS_RST_LOWER))
        else $error("lower reset lines moved without a write");
    awake_gate_a: assert property (!CPU_SLEEP [*2] |->
        CLOCK_ENABLE.sram_sleep_clock_enable && CLOCK_ENABLE.flash_interface_clock_enable)
        else $error("memory or flash clock stopped while awake");
endmodule // prcg_chk

bind prcg_top prcg_chk i_chk (.SYS_CLK, .RST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I,
    .WB_DAT_O, .WB_ACK_O, .WB_ERR_O, .CPU_SLEEP, .UPPER_RESET, .LOWER_RESET, .CLOCK_ENABLE);

/* verif/prcg_top_tb.sv */
// testbench: register access, reset lines and clock gates of prcg_top
`timescale 1ns/1ps
module prcg_top_tb import prcg_pkg::*;;
    logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, slp = 1'b0, ack, err;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wd = 32'h0, rd, u, l, g;
    logic [31:0] m [3];
    logic [32:0] exp_q [$];
    prcg_upper_s up;
    prcg_lower_s lo;
    prcg_gate_s  ge;
    int          n_mismatch = 0, comparisons = 0, cyc_cnt = 0;
    localparam logic [31:0] MSK [3] = '{PRCG_MASK_RST_UPPER, PRCG_MASK_RST_LOWER, PRCG_MASK_CLK_GATE};
    always #5 clk = ~clk;
    prcg_top i_dut (.SYS_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(rd), .WB_ACK_O(ack), .WB_ERR_O(err), .CPU_SLEEP(slp),
        .UPPER_RESET(up), .LOWER_RESET(lo), .CLOCK_ENABLE(ge));
    // =============
    // helper tasks
    task automatic cmp(input string n, input logic [32:0] e, input logic [32:0] v);
        comparisons++;
        if (v !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", n, e, v);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // request held until the answering edge, then released for a cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, sel, wd} <= {2'b11, w, a, s, d};
        do @(posedge clk); while (!(ack || err));
        {cyc, stb} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        logic [31:0] bm;
        int          k;
        bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        k = (a - 8'h0c) >> 2;
        wb(1'b1, a, s, d);
        if (k < 3) m[k] = ((m[k] & ~bm) | (d & bm)) & MSK[k];
    endtask
    task automatic rdq(input logic [7:0] a);
        int k;
        k = (a - 8'h0c) >> 2;
        exp_q.push_back(k < 3 ? {1'b0, m[k]} : {1'b1, 32'h0});
        wb(1'b0, a, 4'hf, 32'h0);
    endtask
    task automatic chk_lines;
        repeat (2) @(posedge clk);
        {u, l, g} = {m[0], m[1], m[2]};
        cmp("upper", {24'h0, u[0], u[9], u[11], u[12], u[14], u[16], u[17], u[18], u[22]}, {24'h0, up});
        cmp("lower", {21'h0, l[0], l[1], l[4], l[8], l[11], l[14], l[17], l[21], l[22], l[28], l[29], l[30]},
            {21'h0, lo});
        cmp("gate", {23'h0, g[0], g[2] | ~slp, g[4] | ~slp, g[6], g[17], g[18], g[19], g[20], g[22], g[24]},
            {23'h0, ge});
    endtask
    // =============
    // read monitor and hang guard
    always @(posedge clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if ((ack || err) && !we && exp_q.size() > 0) cmp("read", exp_q.pop_front(), {err, rd});
        if (cyc_cnt > 5000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    // =============
    // tests
    initial begin
        void'($urandom(32'h4e5ab55d));
        m = '{32'h0, 32'h0, 32'h14};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int a = 12; a <= 24; a += 4) rdq(8'(a));
        chk_lines();
        $display("test reset values done");
        // random byte lanes with idle cycles between accesses, unmapped writes ignored
        for (int i = 0; i < 40; i++) begin
            slp <= 1'($urandom);
            wr(8'h0c + 8'(4 * ($urandom % 4)), 4'($urandom), $urandom);
            for (int a = 12; a <= 24; a += 4) rdq(8'(a));
            chk_lines();
        end
        $display("test random access done");
        repeat (3) @(posedge clk);
        print_verdict();
    end
endmodule // prcg_top_tb
